// >>> tb/mbt_rx_model.sv
// Receiver model sampling the serial line at fixed points of each bit
`timescale 1ns/100ps
module mbt_rx_model
(
  input wire logic core_clk_i,
  input wire logic line_i,
  input wire logic start_i,
  input wire logic manch_i,
  input int period_i,
  input int nbits_i,
  output logic [7:0] bits_o,
  output logic done_o,
  output int errs_o
);
  int t = 0; // Core cycles since the load
  initial done_o = 1'b1;
  initial bits_o = 8'h00;
  initial errs_o = 0;

  always @(posedge core_clk_i)
  begin
    if (start_i)
      t = 1;
    else if (!done_o)
      t = t + 1;
    // Load pulse arms a new frame
    if (start_i)
    begin
      done_o <= 1'b0;
      errs_o <= 0;
    end
    else if (!done_o)
    begin
      if (t % period_i == period_i / 4)
        bits_o[t / period_i] <= line_i;
      // Second half must be the inverse in Manchester code
      if (manch_i && t % period_i == 3 * period_i / 4 && line_i === bits_o[t / period_i])
        errs_o <= errs_o + 1;
      if (t >= nbits_i * period_i)
        done_o <= 1'b1;
    end
  end
endmodule : mbt_rx_model

// >>> tb/mbt_tx_checker.sv
// Port timing checker for the serial output generator
`timescale 1ns/100ps
module mbt_tx_checker
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic serial_out_pin_o,
  input wire logic tx_load_irq_o
);
  // One clock domain, reset disables all checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  // A bit lasts at least eight core cycles, so loads are spaced
  irq_space_a: assert property (tx_load_irq_o |=> (!tx_load_irq_o) [*7])
    else $error("load pulses closer than one shortest bit");
  wr_answer_a: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready) |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after accept");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
    && s_axi_awready && s_axi_wready)
    else $error("write channel not freed after response");
  // Response stands until the master takes it
  wr_block_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after accept");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  idle_start_a: assert property ($rose(nrst_i) |-> !serial_out_pin_o
    && !tx_load_irq_o)
    else $error("line not low idle after reset");

  // Main scenarios reached
  cover property (tx_load_irq_o);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property ($fell(serial_out_pin_o));
endmodule : mbt_tx_checker

bind mbt_tx mbt_tx_checker i_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .serial_out_pin_o(serial_out_pin_o), .tx_load_irq_o(tx_load_irq_o));

// >>> tb/tb.sv
// Self-checking bench for the serial output generator
`timescale 1ns/100ps
module tb;
  import mbt_pkg::*;
  //----------------------------------------------------------------
  // Signals
  //----------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, pin, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_count = 0, samples_checked = 0, cyc = 0, last_irq = 0, irq_gap = 0;
  logic manch = 1'b1; // Decoding mode of the receiver
  int period = 8, nbits = 1;
  logic [7:0] rx_bits;
  logic rx_done;
  int rx_errs;
  // Frame row: mode, clock select, divisor, bit count, data
  typedef struct packed {logic [7:0] mode, sel, div, cnt, data;} mbt_row_s;
  mbt_row_s rows [5] = '{40'h90_00_00_07_a5, 40'h80_00_05_04_16, 40'h92_01_04_00_01,
    40'h82_00_1f_06_4b, 40'h91_00_06_02_05};

  initial forever #50 core_clk_i = ~core_clk_i;

  mbt_tx i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_out_pin_o(pin), .tx_load_irq_o(irq));
  mbt_rx_model i_rx (.core_clk_i(core_clk_i), .line_i(pin), .start_i(irq), .manch_i(manch),
    .period_i(period), .nbits_i(nbits), .bits_o(rx_bits), .done_o(rx_done), .errs_o(rx_errs));

  // Cycle count, load spacing and hang guard
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (irq)
    begin
      irq_gap <= cyc - last_irq;
      last_irq <= cyc;
    end
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  //----------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // Write one register, check the response code
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
    @(posedge core_clk_i);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk_i);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask : wr

  // Read one register, check data and response
  task automatic rd(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er = 2'h0);
    @(posedge core_clk_i);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk_i);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", {24'h000000, e}, rdata);
    chk("rresp", er, rresp);
  endtask : rd

  // Wait for a load pulse and let its updates land
  task automatic wait_irq;
    do
      @(posedge core_clk_i);
    while (irq !== 1'b1);
    #1;
  endtask : wait_irq

  // Configure with the engine stopped, then send one frame
  task automatic run_row(input mbt_row_s r);
    period = 2 * ((r.div[4:0] < 5'h04) ? 4 : int'(r.div[4:0])) * (1 << r.sel);
    nbits = r.cnt + 1;
    manch = !r.mode[POS_FORMAT];
    wr(IDX_MODE_CTRL, r.mode & 8'h7f);
    wr(IDX_CLK_SEL, r.sel);
    wr(IDX_DIVISOR, r.div);
    wr(IDX_BIT_COUNT, r.cnt);
    wr(IDX_MODE_CTRL, r.mode);
    wr(IDX_TX_BUFFER, r.data);
    wait_irq();
    do
      @(posedge core_clk_i);
    while (!rx_done);
    for (int i = 0; i < nbits; i++)
      chk("bit", r.mode[POS_ORDER] ? r.data[i] : r.data[r.cnt - i], rx_bits[i]);
    chk("half", 0, rx_errs);
    repeat (period) @(posedge core_clk_i);
    chk("idle", r.mode[POS_IDLE], pin);
    wr(IDX_MODE_CTRL, r.mode & 8'h7f);
  endtask : run_row

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  //----------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(IDX_MODE_CTRL, RST_MODE_CTRL);
    rd(IDX_CLK_SEL, 8'h00);
    rd(IDX_DIVISOR, 8'h1f);
    rd(IDX_STATUS, 8'h00);
    chk("pin", 0, pin);
    wr(IDX_MODE_CTRL, 8'h7f);
    rd(IDX_MODE_CTRL, 8'h13);
    chk("pin", 1, pin);
    wr(IDX_CLK_SEL, 8'hff);
    rd(IDX_CLK_SEL, 8'h07);
    wr(IDX_DIVISOR, 8'hff);
    rd(IDX_DIVISOR, 8'h1f);
    wr(16'h0100, 8'h55, RESP_SLVERR);
    rd(16'h0100, 8'h00, RESP_SLVERR);
    foreach (rows[i])
      run_row(rows[i]);
    // Chained frames: early write is seamless, late write adds two base clocks
    wr(IDX_DIVISOR, 8'h10);
    wr(IDX_BIT_COUNT, 8'h01);
    wr(IDX_MODE_CTRL, 8'h90);
    nbits = 2;
    period = 32;
    wr(IDX_TX_BUFFER, 8'h02);
    wait_irq();
    wr(IDX_BIT_COUNT, 8'h01);
    wr(IDX_TX_BUFFER, 8'h01);
    wait_irq();
    chk("gap", 64, irq_gap);
    repeat (50) @(posedge core_clk_i);
    wr(IDX_TX_BUFFER, 8'h03);
    // Late value waits while the last bit is still shifting
    rd(IDX_STATUS, 8'h03);
    wait_irq();
    chk("gap", 66, irq_gap);
    // Second reset in mid-run, applied at a clock edge
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(IDX_MODE_CTRL, RST_MODE_CTRL);
    chk("pin", 0, pin);
    end_sim();
  end
endmodule : tb

// >>> verilog/mbt_baud_gen.sv
// Base clock prescaler and baud divider
`timescale 1ns/100ps
module mbt_baud_gen
  import mbt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  mbt_timing_if.gen tim
);

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] pre;  // Free running prescaler
    logic [4:0] kcnt; // Divisor counter
    logic baud;       // Baud clock level
  } mbt_gen_s;

  mbt_gen_s st_q;
  mbt_gen_s st_d;
  logic [2:0] sel;    // Clamped select code
  logic [4:0] k_eff;  // Effective divisor
  logic [4:0] pmask;  // Prescaler mask

  //--------------------------------------------------------------------
  // Decode
  //--------------------------------------------------------------------
  // Codes above five act as five
  assign sel = (tim.clk_sel > SEL_MAX) ? SEL_MAX : tim.clk_sel;
  // [RQ12] Divide by power of two
  assign pmask = 5'((6'h01 << sel) - 6'h01);
  // [RQ14] Floor the divisor at four
  assign k_eff = (tim.divisor < K_MIN) ? K_MIN : tim.divisor;

  assign tim.base_tick = ((st_q.pre & pmask) == pmask);
  assign tim.pre_half = (st_q.kcnt == k_eff - 5'h01);
  assign tim.half_tick = tim.base_tick && tim.pre_half;
  assign tim.baud_lvl = st_q.baud;

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.pre = st_q.pre + 5'h01;
    if (tim.restart)
    begin
      // Align to the start of a bit
      st_d.kcnt = 5'h00;
      st_d.baud = 1'b0;
    end
    else if (tim.half_tick)
    begin
      // [RQ15] Halve the counter output
      st_d.kcnt = 5'h00;
      st_d.baud = ~st_q.baud;
    end
    else if (tim.base_tick)
    begin
      st_d.kcnt = st_q.kcnt + 5'h01;
    end
  end

  // State register
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule : mbt_baud_gen

// >>> verilog/mbt_pkg.sv
// Package of constants and types for the serial output generator
//----------------------------------------------------------------------
// What this block does
// [RQ1] Software writes next buffer within window a
// [RQ2] Guard window starts half baud plus one base
// [RQ3] Late buffer write starts next frame two bases later
// [RQ4] Bit sent at counter zero is the last
// [RQ5] Software writes bit count before the buffer
// [RQ6] Format bit one selects plain bit output
// [RQ7] Mode control resets to 10h; bit 7 enables
// [RQ8] Order bit zero MSB first, one LSB first
// [RQ9] Suspended pin drives the idle level bit
// [RQ10] Software stops before changing order, format, idle
// [RQ11] Mode control takes byte and bit writes
// [RQ12] Base clock select resets 00h, divides by 2^n
// [RQ13] Software stops before changing base clock select
// [RQ14] Divisor resets 1fh; below four acts as four
// [RQ15] Baud clock is divisor output halved again
// [RQ16] Software stops before changing the divisor
// [RQ17] Software keeps baud error within receiver tolerance
// [RQ18] Start copies count and buffer, raises load request
// [RQ19] Manchester output is data XOR baud clock
// [RQ20] Unused control bits always read zero
//----------------------------------------------------------------------
package mbt_pkg;

  // Register indices; byte address is four times the index
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_MODE_CTRL = 16'hff4c;
  localparam logic [15:0] IDX_CLK_SEL = 16'hff4d;
  localparam logic [15:0] IDX_DIVISOR = 16'hff4e;
  localparam logic [15:0] IDX_BIT_COUNT = 16'hff50;
  localparam logic [15:0] IDX_TX_BUFFER = 16'hff51;
  localparam logic [15:0] IDX_STATUS = 16'hff52;

  // Reset values
  localparam logic [7:0] RST_MODE_CTRL = 8'h10;
  localparam logic [7:0] RST_CLK_SEL = 8'h00;
  localparam logic [7:0] RST_DIVISOR = 8'h1f;

  // Writable bit masks; all other bits stay zero
  localparam logic [7:0] MASK_MODE_CTRL = 8'h93;
  localparam logic [7:0] MASK_CLK_SEL = 8'h07;
  localparam logic [7:0] MASK_DIVISOR = 8'h1f;

  // Field positions in the mode control register
  localparam int POS_ENABLE = 7;
  localparam int POS_ORDER = 4;
  localparam int POS_FORMAT = 1;
  localparam int POS_IDLE = 0;

  // Status register field positions
  localparam int POS_ST_BUSY = 0;
  localparam int POS_ST_PEND = 1;
  localparam int POS_ST_GAP = 2;

  // Timing figures, in base clocks or codes
  localparam logic [4:0] K_MIN = 5'h04;
  localparam logic [2:0] SEL_MAX = 3'h5;
  localparam logic [1:0] GAP_TICKS = 2'h2;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Transmit sequencer states
  typedef enum logic [1:0] {MBT_IDLE, MBT_SHIFT, MBT_GAP} mbt_state_e;

endpackage : mbt_pkg

// >>> verilog/mbt_timing_if.sv
// Interface between the transmit core and its baud timing generator
`timescale 1ns/100ps
interface mbt_timing_if;
  logic restart;     // Hold timing at start of a bit
  logic [2:0] clk_sel; // Base clock select code
  logic [4:0] divisor; // Raw divisor field
  logic base_tick;   // One base clock enable pulse
  logic half_tick;   // Divisor counter output pulse
  logic baud_lvl;    // Baud clock level, low in first half
  logic pre_half;    // Last base clock before half boundary

  modport gen (input restart, input clk_sel, input divisor,
               output base_tick, output half_tick, output baud_lvl, output pre_half);
  modport core (output restart, output clk_sel, output divisor,
                input base_tick, input half_tick, input baud_lvl, input pre_half);
endinterface : mbt_timing_if

// >>> verilog/mbt_tx.sv
// Serial output generator: registers, AXI4-Lite slave and transmit core
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
module mbt_tx
  import mbt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [mbt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [mbt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic serial_out_pin_o,
  output logic tx_load_irq_o
);

  //--------------------------------------------------------------------
  // Register selector
  //--------------------------------------------------------------------
  typedef enum logic [2:0] {
    MBT_R_NONE, MBT_R_MODE, MBT_R_CLK, MBT_R_DIV, MBT_R_CNT, MBT_R_BUF, MBT_R_STAT
  } mbt_reg_e;

  // Word index to register; used by both bus channels
  function automatic mbt_reg_e reg_decode(input logic [ADDR_W-1:0] addr);
    logic [15:0] idx;
    idx = 16'(addr[ADDR_W-1:2]);
    if (idx == IDX_MODE_CTRL)
      reg_decode = MBT_R_MODE;
    else if (idx == IDX_CLK_SEL)
      reg_decode = MBT_R_CLK;
    else if (idx == IDX_DIVISOR)
      reg_decode = MBT_R_DIV;
    else if (idx == IDX_BIT_COUNT)
      reg_decode = MBT_R_CNT;
    else if (idx == IDX_TX_BUFFER)
      reg_decode = MBT_R_BUF;
    else if (idx == IDX_STATUS)
      reg_decode = MBT_R_STAT;
    else
      reg_decode = MBT_R_NONE;
  endfunction : reg_decode

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mode;       // Mode control
    logic [7:0] clk_sel;    // Base clock select
    logic [7:0] divisor;    // Baud divisor
    logic [2:0] bit_count;  // Bit count for next load
    logic [7:0] tx_buf;     // Transmit buffer
    logic pending;          // Buffer written, not yet loaded
    logic late;             // Buffer written inside guard
    mbt_state_e state;      // Sequencer state
    logic [2:0] cnt;        // Bits left counter
    logic [7:0] shift;      // Shift register
    logic [1:0] gap;        // Base clocks spent in gap
    logic pin;              // Output pin level
    logic irq;              // Load request pulse
    logic aw_full;          // Write address held
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;           // Write data held
    logic [7:0] w_data;
    logic w_lane;           // Low byte lane enabled
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } mbt_core_s;

  mbt_core_s st_q;
  mbt_core_s st_d;
  mbt_timing_if tim();
  logic enable;       // Operation enabled
  logic lsb_first;    // Shift order
  logic plain_fmt;    // Bit sequential format
  logic idle_lvl;     // Level while suspended
  logic cur_bit;      // Data bit now on the line
  logic bit_end;      // Last base clock of a bit
  logic in_guard;     // Inside the guard window
  logic load;         // Start of a transfer
  mbt_reg_e wsel;     // Write target
  mbt_reg_e rsel;     // Read target

  //--------------------------------------------------------------------
  // Baud timing
  //--------------------------------------------------------------------
  mbt_baud_gen u_baud (
    .core_clk_i (core_clk_i),
    .nrst_i (nrst_i),
    .tim (tim)
  );

  assign tim.clk_sel = st_q.clk_sel[2:0];
  assign tim.divisor = st_q.divisor[4:0];
  // Timing idles at bit start unless shifting
  assign tim.restart = (st_q.state != MBT_SHIFT) || load;

  //--------------------------------------------------------------------
  // Control decode
  //--------------------------------------------------------------------
  assign enable = st_q.mode[POS_ENABLE];
  // [RQ8] Order bit selects shift end
  assign lsb_first = st_q.mode[POS_ORDER];
  assign plain_fmt = st_q.mode[POS_FORMAT];
  assign idle_lvl = st_q.mode[POS_IDLE];
  assign cur_bit = lsb_first ? st_q.shift[0] : st_q.shift[7];
  assign bit_end = tim.half_tick && tim.baud_lvl;
  // [RQ2] Half baud plus one base clock
  assign in_guard = (st_q.state == MBT_SHIFT) && (st_q.cnt == 3'h0)
                    && (tim.baud_lvl || tim.pre_half);
  assign wsel = reg_decode(st_q.aw_addr);
  assign rsel = reg_decode(s_axi_araddr);

  // Load when a buffer value waits and the line is free
  always_comb
  begin
    load = 1'b0;
    if (enable && st_q.pending)
    begin
      if (st_q.state == MBT_IDLE)
        load = 1'b1;
      // [RQ4] Counter zero marks the last bit
      else if (st_q.state == MBT_SHIFT && bit_end && st_q.cnt == 3'h0 && !st_q.late)
        load = 1'b1;
      // [RQ3] Two base clocks after last bit
      else if (st_q.state == MBT_GAP && tim.base_tick && st_q.gap == GAP_TICKS - 2'h1)
        load = 1'b1;
    end
  end

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.irq = 1'b0;

    // Transmit sequencer
    case (st_q.state)
      MBT_IDLE:
      begin
        st_d.gap = 2'h0;
      end
      MBT_SHIFT:
      begin
        if (bit_end)
        begin
          if (st_q.cnt == 3'h0)
          begin
            // Last bit done: chain, wait out gap, or stop
            if (st_q.pending && st_q.late)
            begin
              st_d.state = MBT_GAP;
              st_d.gap = 2'h0;
            end
            else
            begin
              st_d.state = MBT_IDLE;
            end
          end
          else
          begin
            st_d.cnt = st_q.cnt - 3'h1;
            st_d.shift = lsb_first ? {1'b0, st_q.shift[7:1]} : {st_q.shift[6:0], 1'b0};
          end
        end
      end
      MBT_GAP:
      begin
        if (tim.base_tick)
          st_d.gap = st_q.gap + 2'h1;
      end
      default:
      begin
        st_d.state = MBT_IDLE;
      end
    endcase

    // [RQ18] Copy count and buffer, pulse request
    if (load)
    begin
      st_d.state = MBT_SHIFT;
      st_d.cnt = st_q.bit_count;
      st_d.shift = lsb_first ? st_q.tx_buf : st_q.tx_buf << (3'h7 - st_q.bit_count);
      st_d.pending = 1'b0;
      st_d.late = 1'b0;
      st_d.irq = 1'b1;
    end

    // Stopping operation aborts any transfer
    if (!enable)
    begin
      st_d.state = MBT_IDLE;
      st_d.pending = 1'b0;
      st_d.late = 1'b0;
    end

    // Output pin
    if (st_d.state != MBT_SHIFT || !enable)
      // [RQ9] Suspended line shows idle level
      st_d.pin = idle_lvl;
    else if (load)
      st_d.pin = plain_fmt ? (lsb_first ? st_d.shift[0] : st_d.shift[7])
                           : (lsb_first ? st_d.shift[0] : st_d.shift[7]);
    // [RQ6] Format bit picks plain data
    else if (plain_fmt)
      st_d.pin = cur_bit;
    else
      // [RQ19] Manchester: data XOR baud
      // Use the baud level of the next cycle so the registered pin inverts at the half boundary
      st_d.pin = cur_bit ^ (tim.baud_lvl ^ tim.half_tick);
    if (!load && st_q.state == MBT_SHIFT && bit_end && st_q.cnt != 3'h0)
      st_d.pin = lsb_first ? st_d.shift[0] : st_d.shift[7];
    else if (!load && st_q.state == MBT_SHIFT && bit_end)
      st_d.pin = idle_lvl;

    // Write channels are taken independently
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_d.w_full = 1'b1;
      st_d.w_data = s_axi_wdata[7:0];
      st_d.w_lane = s_axi_wstrb[0];
    end

    // Perform the write once both halves are held
    if (st_q.aw_full && st_q.w_full && !st_q.bvalid)
    begin
      st_d.aw_full = 1'b0;
      st_d.w_full = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = RESP_OKAY;
      if (wsel == MBT_R_NONE)
        st_d.bresp = RESP_SLVERR;
      else if (st_q.w_lane)
      begin
        if (wsel == MBT_R_MODE)
          // [RQ11] Full byte, masked to live bits
          // [RQ20] Unused bits forced to zero
          st_d.mode = st_q.w_data & MASK_MODE_CTRL;
        else if (wsel == MBT_R_CLK)
          st_d.clk_sel = st_q.w_data & MASK_CLK_SEL;
        else if (wsel == MBT_R_DIV)
          st_d.divisor = st_q.w_data & MASK_DIVISOR;
        else if (wsel == MBT_R_CNT)
          st_d.bit_count = st_q.w_data[2:0];
        else if (wsel == MBT_R_BUF && st_d.mode[POS_ENABLE])
        begin
          // Write wins over a same-cycle load
          st_d.tx_buf = st_q.w_data;
          st_d.pending = 1'b1;
          st_d.late = in_guard;
        end
      end
    end
    if (st_q.bvalid && s_axi_bready)
      st_d.bvalid = 1'b0;

    // Read channel, answer one cycle after address
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_d.rvalid = 1'b1;
      st_d.rresp = RESP_OKAY;
      st_d.rdata = 32'h0;
      if (rsel == MBT_R_MODE)
        st_d.rdata[7:0] = st_q.mode;
      else if (rsel == MBT_R_CLK)
        st_d.rdata[7:0] = st_q.clk_sel;
      else if (rsel == MBT_R_DIV)
        st_d.rdata[7:0] = st_q.divisor;
      else if (rsel == MBT_R_CNT)
        st_d.rdata[2:0] = st_q.bit_count;
      else if (rsel == MBT_R_BUF)
        st_d.rdata[7:0] = st_q.tx_buf;
      else if (rsel == MBT_R_STAT)
      begin
        st_d.rdata[POS_ST_BUSY] = (st_q.state != MBT_IDLE);
        st_d.rdata[POS_ST_PEND] = st_q.pending;
        st_d.rdata[POS_ST_GAP] = (st_q.state == MBT_GAP);
      end
      else
        st_d.rresp = RESP_SLVERR;
    end
    else if (st_q.rvalid && s_axi_rready)
      st_d.rvalid = 1'b0;
  end

  //--------------------------------------------------------------------
  // State register
  //--------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      st_q <= '0;
      // [RQ7] Mode control reset value
      st_q.mode <= RST_MODE_CTRL;
      // [RQ12] Base clock select reset value
      st_q.clk_sel <= RST_CLK_SEL;
      // [RQ14] Divisor reset value
      st_q.divisor <= RST_DIVISOR;
      st_q.state <= MBT_IDLE;
      st_q.bresp <= RESP_OKAY;
      st_q.rresp <= RESP_OKAY;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign s_axi_awready = !st_q.aw_full;
  assign s_axi_wready = !st_q.w_full;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign serial_out_pin_o = st_q.pin;
  assign tx_load_irq_o = st_q.irq;

endmodule : mbt_tx
